// file: rtl/ulpm_defs.svh
// ulpm_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the lpm control design files
`ifndef ULPM_DEFS_SVH
`define ULPM_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ULPM_OFF_CTRL1      12'h000
`define ULPM_OFF_MODE       12'h004
`define ULPM_OFF_STATUS     12'h008
`define ULPM_OFF_LINK       12'h00C
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define ULPM_XMT_BIT        16
`define ULPM_EP_HI          15
`define ULPM_EP_LO          12
`define ULPM_RWAKE_BIT      8
`define ULPM_HIRD_HI        7
`define ULPM_HIRD_LO        4
`define ULPM_LSTATE_HI      3
`define ULPM_LSTATE_LO      0
`define ULPM_CTRL1_WMASK    32'h0001_F1FF
`define ULPM_CTRL1_RESET    32'h0000_0000
// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define ULPM_HOST_BIT       0
`define ULPM_EN_HI          2
`define ULPM_EN_LO          1
`define ULPM_EN_ARMED       2'h3
`define ULPM_LSTATE_L1      4'h1
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ULPM_CLK_MHZ        125
`define ULPM_RESUME_BASE_US 50
`define ULPM_RESUME_STEP_US 75
`define ULPM_BASE_CYC       (`ULPM_RESUME_BASE_US * `ULPM_CLK_MHZ)
`define ULPM_STEP_CYC       (`ULPM_RESUME_STEP_US * `ULPM_CLK_MHZ)
`define ULPM_MAX_TIMEOUTS   3

`endif

// file: rtl/ulpm_pkg.sv
// ulpm_pkg.sv: types shared by the lpm control design files
// assumes: nothing beyond a systemverilog compiler
package ulpm_pkg;

  typedef enum logic [1:0] {
    ULPM_HS_NONE,
    ULPM_HS_ACK,
    ULPM_HS_NYET
  } ulpm_hs_t;

  typedef enum logic [1:0] {
    ULPM_ST_IDLE,
    ULPM_ST_SEND,
    ULPM_ST_WAIT,
    ULPM_ST_SLEEP
  } ulpm_state_t;

endpackage : ulpm_pkg

// file: rtl/ulpm_ctl_if.sv
// ulpm_ctl_if.sv: carrier between register file and link engine
// assumes: one clock domain
`timescale 1ns/1ps
interface ulpm_ctl_if;
  logic        xmt;
  logic        host_mode;
  logic [1:0]  lpm_en;
  logic        xmt_clr;
  logic        sw_event;
  logic        in_l1;
  logic        rwake_used;
  modport regs (output xmt, host_mode, lpm_en, input xmt_clr, sw_event, in_l1, rwake_used);
  modport eng  (input xmt, host_mode, lpm_en, output xmt_clr, sw_event, in_l1, rwake_used);
endinterface : ulpm_ctl_if

// file: rtl/ulpm_resume_timer.sv
// ulpm_resume_timer.sv: counts the minimum resume drive time
// assumes: start is a one-cycle pulse on hclk
`timescale 1ns/1ps
`include "ulpm_defs.svh"
module ulpm_resume_timer #(
  parameter int BASE_CYC = `ULPM_BASE_CYC,
  parameter int STEP_CYC = `ULPM_STEP_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic [3:0] hird,
  output logic            busy
);
  logic [17:0] cnt_ff;
  logic [17:0] nxt_cnt;

  // resume time = base + hird * step
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = 18'(BASE_CYC) + 18'(STEP_CYC) * 18'(hird);
    end else if (cnt_ff != 18'h0) begin
      nxt_cnt = cnt_ff - 18'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 18'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 18'h0);
endmodule : ulpm_resume_timer

// file: rtl/ulpm_link_ctrl.sv
// ulpm_link_ctrl.sv: lpm control register and l1 entry logic
// assumes: ahb-lite single master, link events are hclk-synchronous pulses
// Summary of operation
// RULE1: device mode with request set enters l1 on next lpm transaction
// RULE2: software writes enable field 11 and request bit together; code holds enable in the mode register, a separate write
// RULE3: armed, all tx fifos empty: ack, self-clear request, raise event
// RULE4: armed, data pending: nyet, request stays set, still raise event
// RULE5: host mode request sends lpm; clears on any token or three timeouts
// RULE6: bits 15..12 hold the endpoint carried in the lpm token
// RULE7: bits 11..9 always read zero
// RULE8: bit 8 enables remote wake for the current suspend only
// RULE9: hird bits 7..4 set resume time 50us plus hird times 75us
// RULE10: link state bits 3..0, only value 1 meaning l1 is valid
// RULE11: host lpm transaction carries endpoint, wake, hird, link state; code sends link state bits 2..0 only
`timescale 1ns/1ps
`include "ulpm_defs.svh"
module ulpm_link_ctrl #(
  parameter int BASE_CYC = `ULPM_BASE_CYC,
  parameter int STEP_CYC = `ULPM_STEP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_lpm_pkt,
  input  wire logic        rx_token,
  input  wire logic        rx_timeout,
  input  wire logic        tx_fifos_empty,
  input  wire logic        resume_seen,
  output logic             hs_valid,
  output ulpm_pkg::ulpm_hs_t hs_code,
  output logic             tx_lpm_start,
  output logic [11:0]      tx_lpm_attr,
  output logic             link_in_l1,
  output logic             remote_wake_en,
  output logic             resume_busy,
  output logic             sw_irq_event
);
  ulpm_ctl_if ctl ();

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic        wr_pend_ff;
  logic        nxt_wr_pend;
  logic [11:0] wr_addr_ff;
  logic [11:0] nxt_wr_addr;
  logic [31:0] ctrl1_ff;
  logic [31:0] nxt_ctrl1;
  logic        host_ff;
  logic        nxt_host;
  logic [1:0]  en_ff;
  logic [1:0]  nxt_en;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        acc;
  logic        wr_ctrl;
  logic [31:0] status_w;
  logic [31:0] mode_w;

  assign acc       = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign wr_ctrl   = wr_pend_ff & (wr_addr_ff == `ULPM_OFF_CTRL1);
  assign mode_w    = {29'h0, en_ff, host_ff};
  assign status_w  = {28'h0, ctl.rwake_used, resume_busy, hs_code == ulpm_pkg::ULPM_HS_NYET,
                      ctl.in_l1};

  always_comb begin
    nxt_wr_pend = acc & hwrite;
    nxt_wr_addr = acc ? {haddr[11:2], 2'b00} : wr_addr_ff;
    nxt_rdata   = rdata_ff;
    nxt_ctrl1   = ctrl1_ff;
    nxt_host    = host_ff;
    nxt_en      = en_ff;
    if (wr_ctrl) begin
      // request, endpoint, wake, hird and link state land together in one write cycle; enable is written through the mode register
      nxt_ctrl1 = hwdata & `ULPM_CTRL1_WMASK; // RULE2 RULE6 RULE8 RULE9 RULE10
    end
    if (wr_pend_ff & (wr_addr_ff == `ULPM_OFF_MODE)) begin
      nxt_host = hwdata[`ULPM_HOST_BIT];
      nxt_en   = hwdata[`ULPM_EN_HI:`ULPM_EN_LO];
    end
    // hardware clear of the request; a software write in the same cycle wins
    if (ctl.xmt_clr && !(wr_ctrl && hwdata[`ULPM_XMT_BIT])) begin
      nxt_ctrl1[`ULPM_XMT_BIT] = 1'b0; // RULE3 RULE5
    end
    // remote wake applies to one suspend only
    if (resume_seen) begin
      nxt_ctrl1[`ULPM_RWAKE_BIT] = 1'b0; // RULE8
    end
    if (acc && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `ULPM_OFF_CTRL1:  nxt_rdata = ctrl1_ff & `ULPM_CTRL1_WMASK; // RULE7
        `ULPM_OFF_MODE:   nxt_rdata = mode_w;
        `ULPM_OFF_STATUS: nxt_rdata = status_w;
        `ULPM_OFF_LINK:   nxt_rdata = {20'h0, tx_lpm_attr};
        default:          nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h0;
      ctrl1_ff   <= `ULPM_CTRL1_RESET;
      host_ff    <= 1'b0;
      en_ff      <= 2'h0;
      rdata_ff   <= 32'h0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      ctrl1_ff   <= nxt_ctrl1;
      host_ff    <= nxt_host;
      en_ff      <= nxt_en;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign ctl.xmt       = ctrl1_ff[`ULPM_XMT_BIT];
  assign ctl.host_mode = host_ff;
  assign ctl.lpm_en    = en_ff;

  // ----------------------------------------------------------------------
  // link engine
  // ----------------------------------------------------------------------
  ulpm_pkg::ulpm_state_t st_ff;
  ulpm_pkg::ulpm_state_t nxt_st;
  logic [1:0]         tmo_ff;
  logic [1:0]         nxt_tmo;
  ulpm_pkg::ulpm_hs_t hs_ff;
  ulpm_pkg::ulpm_hs_t nxt_hs;
  logic               hsv_ff;
  logic               nxt_hsv;
  logic               start_ff;
  logic               nxt_start;
  logic               clr_ff;
  logic               nxt_clr;
  logic               evt_ff;
  logic               nxt_evt;
  logic               rw_ff;
  logic               nxt_rw;
  logic               armed;
  logic               lstate_ok;

  assign armed     = ctl.xmt & (ctl.lpm_en == `ULPM_EN_ARMED);
  assign lstate_ok = ctrl1_ff[`ULPM_LSTATE_HI:`ULPM_LSTATE_LO] == `ULPM_LSTATE_L1; // RULE10

  always_comb begin
    nxt_st    = st_ff;
    nxt_tmo   = tmo_ff;
    nxt_hs    = hs_ff;
    nxt_hsv   = 1'b0;
    nxt_start = 1'b0;
    nxt_clr   = 1'b0;
    nxt_evt   = 1'b0;
    nxt_rw    = rw_ff;
    case (st_ff)
      ulpm_pkg::ULPM_ST_IDLE: begin
        if (ctl.host_mode) begin
          // no restart while the self-clear is still in flight
          if (ctl.xmt && !clr_ff) begin
            nxt_start = 1'b1; // RULE5 RULE11
            nxt_tmo   = 2'h0;
            nxt_st    = ulpm_pkg::ULPM_ST_WAIT;
          end
        end else if (armed && rx_lpm_pkt && lstate_ok) begin
          nxt_hsv = 1'b1;
          nxt_evt = 1'b1; // RULE3 RULE4
          if (tx_fifos_empty) begin
            nxt_hs  = ulpm_pkg::ULPM_HS_ACK; // RULE3
            nxt_clr = 1'b1;
            nxt_rw  = ctrl1_ff[`ULPM_RWAKE_BIT];
            nxt_st  = ulpm_pkg::ULPM_ST_SLEEP; // RULE1
          end else begin
            nxt_hs  = ulpm_pkg::ULPM_HS_NYET; // RULE4
          end
        end
      end
      ulpm_pkg::ULPM_ST_WAIT: begin
        if (rx_token) begin
          nxt_clr = 1'b1; // RULE5
          nxt_evt = 1'b1;
          nxt_rw  = ctrl1_ff[`ULPM_RWAKE_BIT];
          nxt_st  = ulpm_pkg::ULPM_ST_SLEEP;
        end else if (rx_timeout) begin
          if (tmo_ff == 2'(`ULPM_MAX_TIMEOUTS - 1)) begin
            nxt_clr = 1'b1; // RULE5
            nxt_evt = 1'b1;
            nxt_st  = ulpm_pkg::ULPM_ST_IDLE;
          end else begin
            nxt_tmo   = tmo_ff + 2'h1;
            nxt_start = 1'b1;
          end
        end
      end
      ulpm_pkg::ULPM_ST_SLEEP: begin
        if (resume_seen) begin
          nxt_rw = 1'b0; // RULE8
          nxt_st = ulpm_pkg::ULPM_ST_IDLE;
        end
      end
      default: nxt_st = ulpm_pkg::ULPM_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff    <= ulpm_pkg::ULPM_ST_IDLE;
      tmo_ff   <= 2'h0;
      hs_ff    <= ulpm_pkg::ULPM_HS_NONE;
      hsv_ff   <= 1'b0;
      start_ff <= 1'b0;
      clr_ff   <= 1'b0;
      evt_ff   <= 1'b0;
      rw_ff    <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      tmo_ff   <= nxt_tmo;
      hs_ff    <= nxt_hs;
      hsv_ff   <= nxt_hsv;
      start_ff <= nxt_start;
      clr_ff   <= nxt_clr;
      evt_ff   <= nxt_evt;
      rw_ff    <= nxt_rw;
    end
  end

  assign ctl.xmt_clr    = clr_ff;
  assign ctl.sw_event   = evt_ff;
  assign ctl.in_l1      = (st_ff == ulpm_pkg::ULPM_ST_SLEEP);
  assign ctl.rwake_used = rw_ff;

  // ----------------------------------------------------------------------
  // outputs and resume timer
  // ----------------------------------------------------------------------
  assign hs_valid       = hsv_ff;
  assign hs_code        = hs_ff;
  assign tx_lpm_start   = start_ff;
  assign link_in_l1     = ctl.in_l1;
  assign remote_wake_en = rw_ff;
  assign sw_irq_event   = ctl.sw_event;
  // endpoint, wake, hird, link state bits 2..0 as sent in the lpm packet
  assign tx_lpm_attr = {ctrl1_ff[`ULPM_EP_HI:`ULPM_EP_LO], ctrl1_ff[`ULPM_RWAKE_BIT],
                        ctrl1_ff[`ULPM_HIRD_HI:`ULPM_HIRD_LO],
                        ctrl1_ff[`ULPM_LSTATE_HI - 1:`ULPM_LSTATE_LO]}; // RULE6 RULE11

  ulpm_resume_timer #(
    .BASE_CYC (BASE_CYC),
    .STEP_CYC (STEP_CYC)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (resume_seen),
    .hird    (ctrl1_ff[`ULPM_HIRD_HI:`ULPM_HIRD_LO]), // RULE9
    .busy    (resume_busy)
  );
endmodule : ulpm_link_ctrl

// file: test/ulpm_link_ctrl_sva.sv
// ulpm_link_ctrl_sva.sv: port checker for the lpm control block
// assumes: bound onto ulpm_link_ctrl, one clock domain
`timescale 1ns/1ps
module ulpm_link_ctrl_sva #(
  parameter int BASE_CYC = 6250,
  parameter int STEP_CYC = 9375
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               rx_lpm_pkt,
  input wire logic               tx_fifos_empty,
  input wire logic               resume_seen,
  input wire logic               hs_valid,
  input wire ulpm_pkg::ulpm_hs_t hs_code,
  input wire logic               tx_lpm_start,
  input wire logic [11:0]        tx_lpm_attr,
  input wire logic               link_in_l1,
  input wire logic               remote_wake_en,
  input wire logic               resume_busy,
  input wire logic               sw_irq_event
);
  // ----
  // resume length helper
  // ----
  int         busy_n_ff;
  logic [3:0] hird_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_n_ff <= 0;
      hird_ff   <= 4'h0;
    end else begin
      busy_n_ff <= resume_busy ? busy_n_ff + 1 : 0;
      if (resume_seen) hird_ff <= tx_lpm_attr[6:3];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // checks
  // ----
  chk_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  chk_hs_cause: assert property (hs_valid |-> $past(rx_lpm_pkt))
    else $error("handshake without lpm packet");
  chk_ack_empty: assert property (hs_valid && hs_code == ulpm_pkg::ULPM_HS_ACK
    |-> $past(tx_fifos_empty) && link_in_l1) else $error("ack with data pending");
  chk_nyet_pending: assert property (hs_valid && hs_code == ulpm_pkg::ULPM_HS_NYET
    |-> !$past(tx_fifos_empty) && !link_in_l1) else $error("nyet with fifos empty");
  chk_irq_with_hs: assert property (hs_valid |-> sw_irq_event)
    else $error("handshake without event");
  chk_start_pulse: assert property (tx_lpm_start |=> !tx_lpm_start)
    else $error("start longer than one cycle");
  chk_wake_drop: assert property (link_in_l1 && resume_seen
    |=> !link_in_l1 && !remote_wake_en) else $error("wake enable kept");
  chk_resume_start: assert property (link_in_l1 && resume_seen |-> ##[1:2] resume_busy)
    else $error("resume timer idle");
  chk_resume_min: assert property ($fell(resume_busy)
    |-> busy_n_ff >= BASE_CYC + STEP_CYC * hird_ff) else $error("resume too short");
endmodule : ulpm_link_ctrl_sva
bind ulpm_link_ctrl ulpm_link_ctrl_sva #(.BASE_CYC(BASE_CYC), .STEP_CYC(STEP_CYC)) sva_inst (
  .hclk, .hresetn, .hreadyout, .hresp, .rx_lpm_pkt, .tx_fifos_empty, .resume_seen,
  .hs_valid, .hs_code, .tx_lpm_start, .tx_lpm_attr, .link_in_l1, .remote_wake_en,
  .resume_busy, .sw_irq_event);

// file: test/ulpm_usb_peer.sv
// ulpm_usb_peer.sv: usb link partner for the lpm control block
// assumes: hclk-synchronous one-cycle event pulses
`timescale 1ns/1ps
module ulpm_usb_peer (
  input  wire logic hclk,
  input  wire logic tx_lpm_start,
  output logic      rx_lpm_pkt,
  output logic      rx_token,
  output logic      rx_timeout,
  output logic      resume_seen
);
  int tmo_n = 3;
  int k     = 0;
  int dly   = 1;
  initial {rx_lpm_pkt, rx_token, rx_timeout, resume_seen} = 4'h0;
  // ----
  // device-mode traffic
  // ----
  task automatic send_lpm;
    @(posedge hclk);
    rx_lpm_pkt <= 1'b1;
    @(posedge hclk);
    rx_lpm_pkt <= 1'b0;
  endtask : send_lpm
  task automatic send_resume;
    @(posedge hclk);
    resume_seen <= 1'b1;
    @(posedge hclk);
    resume_seen <= 1'b0;
  endtask : send_resume
  // ----
  // host-mode answer: timeouts, then a token
  // ----
  always @(posedge hclk) begin
    if (tx_lpm_start === 1'b1) begin
      repeat (dly) @(posedge hclk);
      if (k < tmo_n) rx_timeout <= 1'b1;
      else rx_token <= 1'b1;
      k++;
      @(posedge hclk);
      rx_timeout <= 1'b0;
      rx_token   <= 1'b0;
    end
  end
endmodule : ulpm_usb_peer

// file: test/testbench.sv
// testbench.sv: self-checking bench for the lpm control block
// assumes: ahb-lite slave answers with zero wait states
`timescale 1ns/1ps
`include "ulpm_defs.svh"
module testbench;
  logic               hclk = 0;
  logic               hresetn = 0;
  logic               hsel = 0, hwrite = 0, tx_fifos_empty = 1, g;
  logic [31:0]        haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0]         htrans = 0;
  logic [2:0]         hsize = 3'h2;
  logic               hreadyout, hresp, rx_lpm_pkt, rx_token, rx_timeout, resume_seen;
  logic               hs_valid, tx_lpm_start, link_in_l1, remote_wake_en, resume_busy;
  logic               sw_irq_event;
  logic [11:0]        tx_lpm_attr;
  ulpm_pkg::ulpm_hs_t hs_code;
  int                 bad_count = 0, comparisons = 0, cyc = 0, starts = 0;
  always #4 hclk = ~hclk;
  ulpm_link_ctrl #(.BASE_CYC(5), .STEP_CYC(3)) ulpm_link_ctrl_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .rx_lpm_pkt, .rx_token, .rx_timeout, .tx_fifos_empty, .resume_seen, .hs_valid,
    .hs_code, .tx_lpm_start, .tx_lpm_attr, .link_in_l1, .remote_wake_en, .resume_busy,
    .sw_irq_event);
  ulpm_usb_peer ulpm_usb_peer_inst (.hclk, .tx_lpm_start, .rx_lpm_pkt, .rx_token,
    .rx_timeout, .resume_seen);
  always @(posedge hclk) begin
    cyc++;
    if (tx_lpm_start === 1'b1) starts++;
    if (cyc == 6000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic lpm_and_wait;
    ulpm_usb_peer_inst.send_lpm();
    #1;
    g = 1'b0;
    repeat (6) begin
      if (hs_valid === 1'b1) break;
      @(posedge hclk);
      #1;
    end
    g = hs_valid;
  endtask : lpm_and_wait
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    bus(1, `ULPM_OFF_CTRL1, 32'hFFFF_FFFF);
    bus(0, `ULPM_OFF_CTRL1, 0);
    chk("ctrl1 mask", 32'h0001_F1FF, rd);
    bus(0, `ULPM_OFF_LINK, 0);
    chk("attr reg", 32'h0000_0FFF, rd);
    chk("attr port", 32'h0000_0FFF, {20'h0, tx_lpm_attr});
    bus(0, 12'h010, 0);
    chk("unmapped", 0, rd);
    bus(1, `ULPM_OFF_CTRL1, 0);
  endtask : t_regs
  task automatic t_ack;
    int n;
    bus(1, `ULPM_OFF_MODE, 32'h6);
    bus(1, `ULPM_OFF_CTRL1, 32'h0001_5121);
    lpm_and_wait();
    chk("ack code", {g, 29'h0, hs_code}, {1'b1, 29'h0, ulpm_pkg::ULPM_HS_ACK});
    chk("ack state", {sw_irq_event, link_in_l1, remote_wake_en}, 3'h7);
    @(posedge hclk);
    bus(0, `ULPM_OFF_CTRL1, 0);
    chk("req cleared", 32'h0000_5121, rd);
    ulpm_usb_peer_inst.send_resume();
    #1;
    chk("left l1", {link_in_l1, remote_wake_en}, 2'h0);
    n = 0;
    repeat (30) begin
      if (resume_busy === 1'b1) n++;
      @(posedge hclk);
      #1;
    end
    chk("resume len", 32'd11, n);
    bus(0, `ULPM_OFF_CTRL1, 0);
    chk("wake cleared", 32'h0000_5021, rd);
  endtask : t_ack
  task automatic t_nyet;
    tx_fifos_empty <= 1'b0;
    bus(1, `ULPM_OFF_CTRL1, 32'h0001_0001);
    lpm_and_wait();
    chk("nyet code", {g, 29'h0, hs_code}, {1'b1, 29'h0, ulpm_pkg::ULPM_HS_NYET});
    chk("nyet state", {sw_irq_event, link_in_l1}, 2'h2);
    bus(0, `ULPM_OFF_CTRL1, 0);
    chk("req kept", 32'h0001_0001, rd);
    bus(0, `ULPM_OFF_STATUS, 0);
    chk("nyet status", 32'h0000_0002, rd);
    tx_fifos_empty <= 1'b1;
    bus(1, `ULPM_OFF_CTRL1, 32'h0000_0001);
    lpm_and_wait();
    chk("idle no answer", 0, g);
    bus(1, `ULPM_OFF_CTRL1, 32'h0001_0002);
    lpm_and_wait();
    chk("reserved state", 0, g);
    bus(1, `ULPM_OFF_CTRL1, 0);
  endtask : t_nyet
  task automatic t_host(input int n, input int d, input int e);
    ulpm_usb_peer_inst.tmo_n = n;
    ulpm_usb_peer_inst.dly = d;
    ulpm_usb_peer_inst.k = 0;
    starts = 0;
    bus(1, `ULPM_OFF_MODE, 32'h7);
    bus(0, `ULPM_OFF_MODE, 0);
    chk("host mode", 32'h0000_0007, rd);
    bus(1, `ULPM_OFF_CTRL1, 32'h0001_3041);
    #1;
    chk("host attr", {4'h3, 1'b0, 4'h4, 3'h1}, {20'h0, tx_lpm_attr});
    bus(0, `ULPM_OFF_CTRL1, 0);
    repeat (40) if (rd[16] !== 1'b0) bus(0, `ULPM_OFF_CTRL1, 0);
    chk("host req", 32'h0000_3041, rd);
    chk("host starts", e, starts);
    chk("host l1", n < 3, link_in_l1);
  endtask : t_host
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_ack();
    t_nyet();
    t_host(3, 1, 3);
    t_host(1, 5, 2);
    finish_test();
  end
endmodule : testbench
